// ===== logic/fls_pkg.sv
/*
  shared constants of the lock-bit set host: flash command codes, status byte
  bit positions, software register offsets and interrupt bit layout.
  assumes a byte-wide flash with a setup/confirm lock-bit command pair.
*/
package fls_pkg;
  // flash command bytes
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER = 8'hf1;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  // status_byte bit positions
  localparam int SB_ENGINE_READY = 7;
  localparam int SB_ERASE_CLEAR_ERR = 5;
  localparam int SB_PROGRAM_SET_ERR = 4;
  localparam int SB_SUPPLY_FAULT = 3;
  localparam int SB_PROTECT = 1;
  localparam logic [7:0] SB_RESERVED_MASK = 8'hfe;
  // avalon word offsets
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_TARGET = 3'h1;
  localparam logic [2:0] REG_STATE = 3'h2;
  localparam logic [2:0] REG_IRQ_STAT = 3'h3;
  localparam logic [2:0] REG_IRQ_CLR = 3'h4;
  localparam logic [2:0] REG_IRQ_EN = 3'h5;
  // command register bits
  localparam int CB_LOCK = 0;
  localparam int CB_MASTER = 1;
  localparam int CB_CLEAR = 2;
  localparam int CB_ARRAY = 3;
  // interrupt bits
  localparam int IRQ_W = 5;
  localparam int EV_DONE = 0;
  localparam int EV_SEQ_ERR = 1;
  localparam int EV_LOCK_FAIL = 2;
  localparam int EV_PROTECT = 3;
  localparam int EV_SUPPLY = 4;
  // one-hot sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WR = 5'b00010,
    ST_WREC = 5'b00100,
    ST_RD = 5'b01000,
    ST_RREC = 5'b10000
  } fls_state_e;
  typedef enum logic [1:0] {
    OP_LOCK = 2'h0,
    OP_SINGLE = 2'h1
  } fls_op_e;
endpackage : fls_pkg

// ===== logic/fls_lock_host.sv
/*
  host controller that sets block or master lock-bits in a byte-wide flash,
  polls its status byte, classifies errors and issues clear-status or
  read-array commands on software request.
  assumes flash pins are synchronous to clk_sys and timing is met by the
  cycle-count parameters; software uses avalon-mm with waitrequest.
*/
// Functional notes
// - lock set is setup write then block or master confirm write
// - status bit 7 high means ready; host polls it and ready pin
// - lock sequences may run back to back, checked each or at end
// - host writes read-array after the last lock sequence; this host writes it only when software sets CB_ARRAY
// - host clears status after an error before retrying; this host clears it only when software sets CB_CLEAR
// - ready pin may drive an interrupt input directly
`timescale 1ns/1ps
module fls_lock_host #(
  parameter int ADDR_W = 21,
  parameter int WE_CYC = 8,
  parameter int REC_CYC = 4,
  parameter int RD_CYC = 12,
  parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic ready_busy_out
);
  localparam logic [7:0] WE_LD = 8'(WE_CYC - 1);
  localparam logic [7:0] REC_LD = 8'(REC_CYC - 1);
  localparam logic [7:0] RD_LD = 8'(RD_CYC - 1);

  // bus slave state
  logic [ADDR_W-1:0] target, next_target;
  logic [fls_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
  logic [31:0] next_readdata;
  logic next_waitrequest, next_irq;
  logic bus_wr, cmd_lock, cmd_master, cmd_clear, cmd_array;
  // sequencer state
  fls_pkg::fls_state_e state, next_state;
  fls_pkg::fls_op_e op, next_op;
  logic confirm_due, next_confirm_due, polling, next_polling, master, next_master;
  logic [7:0] cnt, next_cnt, status_byte, next_status_byte;
  logic [fls_pkg::IRQ_W-1:0] evt, next_evt;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [7:0] next_dq_out;
  logic next_dq_oe, next_ce_n, next_we_n, next_oe_n;
  logic [7:0] sampled;

  assign bus_wr = avs_write && !avs_waitrequest;
  assign cmd_lock = bus_wr && avs_address == fls_pkg::REG_CMD
                    && avs_writedata[fls_pkg::CB_LOCK];
  assign cmd_master = avs_writedata[fls_pkg::CB_MASTER];
  assign cmd_clear = bus_wr && avs_address == fls_pkg::REG_CMD
                     && avs_writedata[fls_pkg::CB_CLEAR];
  assign cmd_array = bus_wr && avs_address == fls_pkg::REG_CMD
                     && avs_writedata[fls_pkg::CB_ARRAY];
  assign sampled = flash_dq_in & fls_pkg::SB_RESERVED_MASK;

  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    next_target = target;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      case (avs_address)
        fls_pkg::REG_TARGET: next_readdata = 32'(target);
        fls_pkg::REG_STATE: begin
          next_readdata = {16'h0000, status_byte, 7'h00, state != fls_pkg::ST_IDLE};
        end
        fls_pkg::REG_IRQ_STAT: next_readdata = 32'(irq_stat);
        fls_pkg::REG_IRQ_EN: next_readdata = 32'(irq_en);
        default: next_readdata = 32'h0000_0000;
      endcase
    end
    if (bus_wr && avs_address == fls_pkg::REG_TARGET) begin
      next_target = avs_writedata[ADDR_W-1:0];
    end
    if (bus_wr && avs_address == fls_pkg::REG_IRQ_EN) begin
      next_irq_en = avs_writedata[fls_pkg::IRQ_W-1:0];
    end
    if (bus_wr && avs_address == fls_pkg::REG_IRQ_CLR) begin
      next_irq_stat = next_irq_stat & ~avs_writedata[fls_pkg::IRQ_W-1:0];
    end
    // new events win over a clear in the same cycle
    next_irq_stat = next_irq_stat | evt;
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      target <= '0;
      irq_en <= '0;
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      target <= next_target;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      irq <= next_irq;
    end
  end

  always_comb begin
    next_state = state;
    next_op = op;
    next_confirm_due = confirm_due;
    next_polling = polling;
    next_master = master;
    next_cnt = cnt;
    next_status_byte = status_byte;
    next_evt = '0;
    next_flash_addr = flash_addr;
    next_dq_out = flash_dq_out;
    next_dq_oe = flash_dq_oe;
    next_ce_n = flash_ce_n;
    next_we_n = flash_we_n;
    next_oe_n = flash_oe_n;
    case (state)
      fls_pkg::ST_IDLE: begin
        if (cmd_lock) begin
          next_op = fls_pkg::OP_LOCK;
          next_master = cmd_master;
          next_confirm_due = 1'b1;
          next_dq_out = fls_pkg::CMD_LOCK_SETUP;
        end else if (cmd_clear) begin
          next_op = fls_pkg::OP_SINGLE;
          next_dq_out = CMD_CLEAR_STATUS;
          next_status_byte = 8'h80;
        end else if (cmd_array) begin
          next_op = fls_pkg::OP_SINGLE;
          next_dq_out = fls_pkg::CMD_READ_ARRAY;
        end
        if (cmd_lock || cmd_clear || cmd_array) begin
          next_flash_addr = target;
          next_dq_oe = 1'b1;
          next_ce_n = 1'b0;
          next_we_n = 1'b0;
          next_cnt = WE_LD;
          next_state = fls_pkg::ST_WR;
        end
      end
      fls_pkg::ST_WR: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = REC_LD;
          next_state = fls_pkg::ST_WREC;
        end
      end
      fls_pkg::ST_WREC: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_dq_oe = 1'b0;
          next_state = fls_pkg::ST_IDLE;
          if (op == fls_pkg::OP_LOCK && confirm_due) begin
            // confirm write selects block or master
            next_confirm_due = 1'b0;
            next_dq_out = master ? fls_pkg::CMD_LOCK_MASTER : fls_pkg::CMD_LOCK_BLOCK;
            next_dq_oe = 1'b1;
            next_ce_n = 1'b0;
            next_we_n = 1'b0;
            next_cnt = WE_LD;
            next_state = fls_pkg::ST_WR;
          end else if (op == fls_pkg::OP_LOCK) begin
            // reads now return the status byte
            next_polling = 1'b1;
            next_cnt = REC_LD;
            next_state = fls_pkg::ST_RREC;
          end
        end
      end
      fls_pkg::ST_RD: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_status_byte = sampled;
          next_cnt = REC_LD;
          next_state = fls_pkg::ST_RREC;
          if (sampled[fls_pkg::SB_ENGINE_READY]) begin
            next_polling = 1'b0;
            next_state = fls_pkg::ST_IDLE;
            next_evt[fls_pkg::EV_DONE] = 1'b1;
            next_evt[fls_pkg::EV_SEQ_ERR] = sampled[fls_pkg::SB_ERASE_CLEAR_ERR]
                                            && sampled[fls_pkg::SB_PROGRAM_SET_ERR];
            next_evt[fls_pkg::EV_LOCK_FAIL] = !sampled[fls_pkg::SB_ERASE_CLEAR_ERR]
                                              && sampled[fls_pkg::SB_PROGRAM_SET_ERR];
            next_evt[fls_pkg::EV_PROTECT] = sampled[fls_pkg::SB_PROTECT];
            next_evt[fls_pkg::EV_SUPPLY] = sampled[fls_pkg::SB_SUPPLY_FAULT];
          end
        end
      end
      fls_pkg::ST_RREC: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (ready_busy_out) begin
          // wait for the ready pin before reading status
          next_ce_n = 1'b0;
          next_oe_n = 1'b0;
          next_cnt = RD_LD;
          next_state = fls_pkg::ST_RD;
        end
      end
      default: next_state = fls_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= fls_pkg::ST_IDLE;
      op <= fls_pkg::OP_LOCK;
      confirm_due <= 1'b0;
      polling <= 1'b0;
      master <= 1'b0;
      cnt <= 8'h00;
      status_byte <= 8'h80;
      evt <= '0;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      confirm_due <= next_confirm_due;
      polling <= next_polling;
      master <= next_master;
      cnt <= next_cnt;
      status_byte <= next_status_byte;
      evt <= next_evt;
      flash_addr <= next_flash_addr;
      flash_dq_out <= next_dq_out;
      flash_dq_oe <= next_dq_oe;
      flash_ce_n <= next_ce_n;
      flash_we_n <= next_we_n;
      flash_oe_n <= next_oe_n;
    end
  end

  a_setup_then_confirm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(flash_we_n) && flash_dq_out == fls_pkg::CMD_LOCK_SETUP && op == fls_pkg::OP_LOCK
    |-> ##[1:300] $fell(flash_we_n) && (flash_dq_out == fls_pkg::CMD_LOCK_BLOCK
        || flash_dq_out == fls_pkg::CMD_LOCK_MASTER))
    else $error("setup write not followed by confirm");
  a_poll_after_confirm: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(flash_we_n) && !confirm_due && op == fls_pkg::OP_LOCK && !flash_oe_n == 1'b0
    && state == fls_pkg::ST_WREC |-> ##[1:20] polling)
    else $error("no status poll after lock confirm");
  a_done_needs_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt[fls_pkg::EV_DONE] |-> status_byte[fls_pkg::SB_ENGINE_READY] && !polling)
    else $error("done raised without ready status");
  a_seq_err_class: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt[fls_pkg::EV_SEQ_ERR] |-> status_byte[5] && status_byte[4] && !evt[fls_pkg::EV_LOCK_FAIL])
    else $error("sequence error misclassified");
  a_lock_fail_class: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt[fls_pkg::EV_DONE] && status_byte[4] && !status_byte[5] |-> evt[fls_pkg::EV_LOCK_FAIL])
    else $error("lock failure not reported");
  a_protect_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt[fls_pkg::EV_DONE] |-> evt[fls_pkg::EV_PROTECT] == status_byte[fls_pkg::SB_PROTECT])
    else $error("protect event mismatch");
  a_supply_event: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt[fls_pkg::EV_DONE] |-> evt[fls_pkg::EV_SUPPLY] == status_byte[fls_pkg::SB_SUPPLY_FAULT])
    else $error("supply event mismatch");
  a_read_waits_ready: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(flash_oe_n) |-> $past(ready_busy_out))
    else $error("status read while busy pin low");
  a_reserved_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(status_byte) |-> !status_byte[0])
    else $error("reserved status bit kept");
  a_sticky_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
    |evt |=> (irq_stat & $past(evt)) == $past(evt))
    else $error("event lost in status");
endmodule : fls_lock_host

// ===== test/fls_flash_model.sv
/*
  flash device model: lock-bit set sequencing, sticky status byte, ready pin.
  assumes the host strobes change synchronously to clk_sys.
*/
`timescale 1ns/1ps
module fls_flash_model #(
  parameter int AW = 21,
  parameter int BUSY = 20
) (
  // host pins
  input wire logic clk_sys,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  output logic [7:0] flash_dq_in,
  output logic ready_busy_out,
  // b0 high volt reset pin, b1 supply low, b2 bad sequence, b3 junk in bit 0
  input wire logic [3:0] fault,
  // observed commands
  output logic [7:0] last_cmd = 8'h00,
  output logic [7:0] prev_cmd = 8'h00,
  output logic [AW-1:0] cmd_addr = '0
);
  logic [7:0] sr = 8'h80;
  logic [7:0] lat = 8'h00;
  logic [7:0] err;
  logic [7:0] wire_q = 8'h00;
  logic we_q = 1'b1;
  logic stat_mode = 1'b0;
  logic wait_cf = 1'b0;
  logic master_lk = 1'b0;
  int busy_cnt = 0;
  // low only while an algorithm runs
  assign ready_busy_out = (busy_cnt == 0);
  always_comb begin
    if (fault[2] || (lat != 8'h01 && lat != 8'hf1)) err = 8'h30;
    else if (fault[1]) err = 8'h18;
    else if (!fault[0] && (lat == 8'hf1 || master_lk)) err = 8'h12;
    else err = 8'h00;
  end
  // status on reads in status mode, 8'h5a otherwise; an undriven bus toggles
  always_comb begin
    if (flash_dq_oe) flash_dq_in = flash_dq_out;
    else if (!flash_ce_n && !flash_oe_n) flash_dq_in = stat_mode ? (sr | {7'h00, fault[3]}) : 8'h5a;
    else flash_dq_in = ~wire_q;
  end
  always @(posedge clk_sys) begin
    wire_q <= flash_dq_in;
    we_q <= flash_we_n;
    if (!flash_we_n && !flash_ce_n) lat <= flash_dq_out;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) sr[7] <= 1'b1;
    end else if (flash_we_n && !we_q) begin
      prev_cmd <= last_cmd;
      last_cmd <= lat;
      cmd_addr <= flash_addr;
      stat_mode <= 1'b1;
      if (wait_cf) begin
        if (err == 8'h00 && lat == 8'hf1) master_lk <= 1'b1;
        sr <= (sr | err) & 8'h7f;
        wait_cf <= 1'b0;
        busy_cnt <= BUSY;
      end else begin
        wait_cf <= (lat == 8'h60);
        if (lat == 8'h50) sr <= 8'h80;
        if (lat == 8'hff) stat_mode <= 1'b0;
      end
    end
  end
endmodule : fls_flash_model

// ===== test/fls_lock_host_tb.sv
/*
  self-checking bench of the lock-bit set host against the flash model.
  assumes default host parameters and avalon access through one task.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module fls_lock_host_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [20:0] flash_addr;
  logic [7:0] dq_out;
  logic dq_oe;
  logic [7:0] dq_in;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic rdy;
  logic [3:0] fault = 4'h0;
  logic [7:0] last_cmd;
  logic [7:0] prev_cmd;
  logic [20:0] cmd_addr;
  logic [4:0] irq_en = 5'h1f;
  logic [31:0] q;
  int error_cnt = 0;
  int cmp_count = 0;
  fls_lock_host fls_lock_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .flash_addr(flash_addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_out(rdy));
  fls_flash_model fls_flash_model_i (.clk_sys(clk_sys), .flash_addr(flash_addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_dq_in(dq_in), .ready_busy_out(rdy), .fault(fault),
    .last_cmd(last_cmd), .prev_cmd(prev_cmd), .cmd_addr(cmd_addr));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task final_report;
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // request held until waitrequest is sampled low at a rising edge
  task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // command write, then wait until the sequencer is idle
  task cmd(input logic [3:0] c);
    int n;
    n = 0;
    bus(1'b1, fls_pkg::REG_CMD, {28'h0, c});
    do begin
      bus(1'b0, fls_pkg::REG_STATE, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    if (n >= 200) error_cnt++;
    repeat (3) @(posedge clk_sys);
  endtask : cmd
  task lock(input logic m, input logic [3:0] f, input logic [7:0] sr, input logic [4:0] ev);
    fault <= f;
    bus(1'b1, fls_pkg::REG_TARGET, 32'h12345 + 32'(m));
    cmd({2'b00, m, 1'b1});
    `CHK(prev_cmd, fls_pkg::CMD_LOCK_SETUP)
    `CHK(last_cmd, m ? fls_pkg::CMD_LOCK_MASTER : fls_pkg::CMD_LOCK_BLOCK)
    `CHK(cmd_addr, 21'h12345 + 21'(m))
    bus(1'b0, fls_pkg::REG_STATE, 32'h0);
    `CHK(q[15:8], sr)
    bus(1'b0, fls_pkg::REG_IRQ_STAT, 32'h0);
    `CHK(q[4:0], ev)
    `CHK(irq, |(ev & irq_en))
    bus(1'b1, fls_pkg::REG_IRQ_CLR, 32'h1f);
    bus(1'b0, fls_pkg::REG_IRQ_STAT, 32'h0);
    `CHK(q[4:0], 5'h00)
  endtask : lock
  task t_reset;
    bus(1'b0, fls_pkg::REG_STATE, 32'h0);
    `CHK(q, 32'h8000)
    `CHK(irq, 1'b0)
    bus(1'b0, 3'h6, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, fls_pkg::REG_IRQ_EN, 32'h1f);
    bus(1'b0, fls_pkg::REG_IRQ_EN, 32'h0);
    `CHK(q[4:0], 5'h1f)
  endtask : t_reset
  task t_clear;
    cmd(4'h4);
    `CHK(last_cmd, 8'h50)
    bus(1'b0, fls_pkg::REG_STATE, 32'h0);
    `CHK(q[15:8], 8'h80)
  endtask : t_clear
  task t_refusals;
    lock(1'b0, 4'h8, 8'h80, 5'h01);
    lock(1'b1, 4'h0, 8'h92, 5'h0d);
    lock(1'b0, 4'h0, 8'h92, 5'h0d);
    t_clear();
    lock(1'b1, 4'h1, 8'h80, 5'h01);
    lock(1'b0, 4'h0, 8'h92, 5'h0d);
    t_clear();
  endtask : t_refusals
  task t_faults;
    irq_en = 5'h00;
    bus(1'b1, fls_pkg::REG_IRQ_EN, 32'h0);
    lock(1'b0, 4'h2, 8'h98, 5'h15);
    t_clear();
    irq_en = 5'h1f;
    bus(1'b1, fls_pkg::REG_IRQ_EN, 32'h1f);
    lock(1'b0, 4'h4, 8'hb0, 5'h03);
    t_clear();
  endtask : t_faults
  task t_array;
    cmd(4'hc);
    `CHK(last_cmd, 8'h50)
    cmd(4'h8);
    `CHK(last_cmd, fls_pkg::CMD_READ_ARRAY)
    `CHK({ce_n, we_n, oe_n, dq_oe}, 4'he)
  endtask : t_array
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_refusals();
    t_faults();
    t_array();
    final_report();
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule : fls_lock_host_tb
